/* File: core/tsh_flag_sync.sv */
/*
  Two-stage synchroniser with edge detection for peripheral inputs.
  Assumes asynchronous inputs and one clock clk_sys with synchronous reset.
*/
`timescale 1ns/10ps
module tsh_flag_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Asynchronous inputs
  input wire logic [WIDTH-1:0] async_in,
  // Synchronised level and one-cycle edge pulses
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  genvar i;

  // One synchroniser per input bit
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic meta_r; // First stage, read only by second stage
      logic sync_r; // Second stage
      logic prev_r; // Delayed copy for edge detection

      // Shift chain; first stage feeds only the second
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end else begin
          meta_r <= async_in[i];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end

      // Edges from the stable stages only
      assign level[i] = sync_r;
      assign rise[i] = sync_r & ~prev_r;
      assign fall[i] = ~sync_r & prev_r;
    end
  endgenerate

endmodule

/* File: core/tsh_sequencer.sv */
/*
  Data transfer sequencer with command/flag handshake to a parallel
  peripheral: start qualifier, flag edge latches, four-state counter,
  transfer flags, operation done and device command output.
  Assumes synchronous host strobes and control word on clk_sys, and
  asynchronous device flag and device end from the peripheral.
*/
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "tsh_defs.svh"
module tsh_sequencer
  import tsh_pkg::*;
#(
  parameter int SETTLE_CYC = `TSH_SETTLE_CYC,
  parameter int PULSE_CYC = `TSH_PULSE_CYC
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic master_reset_n,
  // Host strobes and control word
  input wire tsh_strobe_t strobes,
  input wire logic [`TSH_CW_WIDTH-1:0] control_word,
  // Configuration jumpers
  input wire tsh_jumper_t jumpers,
  // Peripheral inputs, asynchronous
  input wire logic device_flag,
  input wire logic device_end,
  // Peripheral command output
  output logic device_command,
  // Sequencer state to the rest of the card
  output logic [3:0] count_onehot,
  output logic operation_done,
  output logic read_transfer,
  output logic write_transfer,
  output logic start_qualifier
);

  // Timer values sized to the counters
  localparam logic [`TSH_TMR_W-1:0] SETTLE_V = `TSH_TMR_W'(SETTLE_CYC);
  localparam logic [`TSH_TMR_W-1:0] PULSE_V = `TSH_TMR_W'(PULSE_CYC);

  // Combined clear from system reset or master reset
  wire clr_all;
  // Synchronised peripheral signals
  logic [1:0] sync_level;
  logic [1:0] sync_rise;
  logic [1:0] sync_fall;
  wire flag_rise;
  wire flag_fall;
  wire dev_end;
  // Strobe trailing edges
  logic [4:0] strb_prev_r;
  wire [4:0] strb_now;
  wire [4:0] strb_trail;
  wire start_evt;
  wire write_evt;
  wire read_evt;
  // Control word bits
  wire byte_mode;
  wire cw_start;
  // Counter state
  tsh_state_t state_r;
  tsh_state_t state_nxt;
  wire in_s0;
  wire in_s1;
  wire in_s2;
  wire in_s3;
  wire step;
  // Qualifiers and latches
  logic start_q_r;
  logic first_flag_r;
  logic end_flag_r;
  logic done_pend_r;
  wire first_edge;
  wire end_edge;
  wire same_edge;
  wire first_flag_qualifier;
  wire end_qualifier;
  wire second_byte_qualifier;
  // Transfer flags
  logic read_xfer_r;
  logic write_xfer_r;
  wire any_xfer;
  // Command path
  wire cmd_req;
  logic cmd_req_prev_r;
  wire cmd_req_rise;
  logic [`TSH_TMR_W-1:0] settle_cnt_r;
  wire settle_done;
  wire cmd_level;
  logic cmd_level_prev_r;
  wire pulse_start;
  logic [`TSH_TMR_W-1:0] pulse_cnt_r;
  wire pulse_active;
  wire cmd_raw;
  logic cmd_out_r;

  assign clr_all = reset | ~master_reset_n;

  // Flag and device end pass two flops before any edge logic
  tsh_flag_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({device_end, device_flag}),
    .level(sync_level),
    .rise(sync_rise),
    .fall(sync_fall)
  );

  // Leading and trailing flag edges, device end level
  assign flag_rise = sync_rise[0];
  assign flag_fall = sync_fall[0];
  assign dev_end = sync_level[1];

  // Control word decode
  assign byte_mode = control_word[`TSH_CW_BYTE_BIT];
  assign cw_start = control_word[`TSH_CW_START_BIT];

  // Strobes as a vector: [4] dw, [3] pw, [2] rnw, [1] pc, [0] dc
  assign strb_now = strobes;
  assign strb_trail = strb_prev_r & ~strb_now;

  // Previous strobe levels for trailing edge detection
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      strb_prev_r <= 5'h00;
    end else begin
      strb_prev_r <= strb_now;
    end
  end

  // Start on any write or read-next trailing edge, control strobes need bit 5
  assign start_evt = strb_trail[4] | strb_trail[3] | strb_trail[2] |
                     ((strb_trail[1] | strb_trail[0]) & cw_start);
  // Write strobes mark a write, the others a read
  assign write_evt = strb_trail[4] | strb_trail[3];
  assign read_evt = strb_trail[2] | strb_trail[1] | strb_trail[0];

  // State decode to one-hot outputs
  assign in_s0 = (state_r == TSH_S0);
  assign in_s1 = (state_r == TSH_S1);
  assign in_s2 = (state_r == TSH_S2);
  assign in_s3 = (state_r == TSH_S3);
  assign count_onehot = {in_s3, in_s2, in_s1, in_s0};

  // Flag edge selection by jumpers
  assign first_edge = jumpers.start_edge_select ? flag_fall : flag_rise;
  assign end_edge = jumpers.end_edge_select ? flag_rise : flag_fall;
  // Both on leading or both on trailing edge
  assign same_edge = jumpers.start_edge_select ^ jumpers.end_edge_select;

  // Qualifiers for each step
  assign first_flag_qualifier = first_flag_r;
  assign end_qualifier = same_edge | end_flag_r | dev_end;
  assign second_byte_qualifier = ~byte_mode | dev_end | first_flag_r;

  // Next state of the sequence counter
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TSH_S0: begin
        // Idle until started
        if (start_q_r) begin
          state_nxt = TSH_S1;
        end
      end
      TSH_S1: begin
        // Wait for the first flag edge
        if (first_flag_qualifier) begin
          state_nxt = TSH_S2;
        end
      end
      TSH_S2: begin
        // Wait for the end of the operation
        if (end_qualifier) begin
          state_nxt = TSH_S3;
        end
      end
      TSH_S3: begin
        // Wait for second byte, or pass straight through
        if (second_byte_qualifier) begin
          state_nxt = TSH_S0;
        end
      end
      default: begin
        state_nxt = TSH_S0;
      end
    endcase
  end

  assign step = (state_nxt != state_r);

  // Counter register; device end forces idle
  always_ff @(posedge clk_sys) begin
    if (clr_all | dev_end) begin
      state_r <= TSH_S0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Start qualifier: set by start event, cleared leaving state 0
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      start_q_r <= 1'b0;
    end else if (start_evt) begin
      start_q_r <= 1'b1;
    end else if (in_s0 & step) begin
      start_q_r <= 1'b0;
    end
  end

  // First flag latch: cleared leaving state 1 and leaving state 3
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      first_flag_r <= 1'b0;
    end else if (first_edge) begin
      first_flag_r <= 1'b1;
    end else if ((in_s1 | in_s3) & step) begin
      first_flag_r <= 1'b0;
    end
  end

  // End flag latch: cleared entering state 1, and entering state 3 in byte mode
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      end_flag_r <= 1'b0;
    end else if (end_edge) begin
      end_flag_r <= 1'b1;
    end else if (in_s0 & step) begin
      end_flag_r <= 1'b0;
    end else if (in_s2 & step & byte_mode) begin
      end_flag_r <= 1'b0;
    end
  end

  // Operation done pending from any step or device end outside state 0
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      done_pend_r <= 1'b0;
    end else if (~in_s0 & (step | dev_end)) begin
      done_pend_r <= 1'b1;
    end else if (operation_done) begin
      done_pend_r <= 1'b0;
    end
  end

  // Done waits in state 0 for a late end edge
  assign operation_done = in_s0 & done_pend_r & end_qualifier;

  // Transfer flags; a new strobe wins over a done in the same cycle
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      read_xfer_r <= 1'b0;
      write_xfer_r <= 1'b0;
    end else begin
      if (write_evt) begin
        write_xfer_r <= 1'b1;
      end else if (operation_done) begin
        write_xfer_r <= 1'b0;
      end
      if (read_evt) begin
        read_xfer_r <= 1'b1;
      end else if (operation_done) begin
        read_xfer_r <= 1'b0;
      end
    end
  end

  assign any_xfer = read_xfer_r | write_xfer_r;

  // Command request in state 1, and state 3 in byte mode; device end inhibits
  assign cmd_req = any_xfer & (in_s1 | (in_s3 & byte_mode)) & ~dev_end;
  assign cmd_req_rise = cmd_req & ~cmd_req_prev_r;

  // Write settle timer restarts on each request
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      cmd_req_prev_r <= 1'b0;
      settle_cnt_r <= '0;
    end else begin
      cmd_req_prev_r <= cmd_req;
      if (cmd_req_rise) begin
        settle_cnt_r <= SETTLE_V;
      end else if (settle_cnt_r != '0) begin
        settle_cnt_r <= settle_cnt_r - `TSH_TMR_W'(1);
      end
    end
  end

  // Writes wait for the settle time, reads do not
  assign settle_done = ~write_xfer_r | (~cmd_req_rise & (settle_cnt_r == '0));
  assign cmd_level = cmd_req & settle_done;
  assign pulse_start = cmd_level & ~cmd_level_prev_r;

  // Pulse width timer started by each command
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      cmd_level_prev_r <= 1'b0;
      pulse_cnt_r <= '0;
    end else begin
      cmd_level_prev_r <= cmd_level;
      if (pulse_start) begin
        pulse_cnt_r <= PULSE_V;
      end else if (pulse_cnt_r != '0) begin
        pulse_cnt_r <= pulse_cnt_r - `TSH_TMR_W'(1);
      end
    end
  end

  assign pulse_active = (pulse_cnt_r != '0);

  // Pulse mode uses fixed width, response mode follows the level
  assign cmd_raw = jumpers.pulse_mode_select ? pulse_active : cmd_level;

  // Registered command with selectable polarity
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      cmd_out_r <= jumpers.command_invert_select ? 1'b1 : 1'b0;
    end else begin
      cmd_out_r <= cmd_raw ^ jumpers.command_invert_select;
    end
  end

  // Outputs
  assign device_command = cmd_out_r;
  assign read_transfer = read_xfer_r;
  assign write_transfer = write_xfer_r;
  assign start_qualifier = start_q_r;

endmodule

/* File: shared/tsh_defs.svh */
/*
  Constants of the transfer sequencer: control word bit positions,
  clock period and handshake timing figures with derived cycle counts.
  Assumes inclusion by bare name from files that need the numbers.
*/
`ifndef TSH_DEFS_SVH
`define TSH_DEFS_SVH

// Control word layout
`define TSH_CW_WIDTH 16
`define TSH_CW_START_BIT 5
`define TSH_CW_BYTE_BIT 13

// Clock period of clk_sys in ns
`define TSH_CLK_NS 100

// Least settle time of write data before the command, in ns
`define TSH_SETTLE_NS 200
// Width of the pulse-mode command, in ns
`define TSH_PULSE_NS 8000

// Least time rounds up, none below one cycle
`define TSH_SETTLE_CYC ((`TSH_SETTLE_NS + `TSH_CLK_NS - 1) / `TSH_CLK_NS)
// Nominal width rounds down
`define TSH_PULSE_CYC (`TSH_PULSE_NS / `TSH_CLK_NS)

// Width of the timing counters
`define TSH_TMR_W 8

`endif

/* File: shared/tsh_pkg.sv */
/*
  Types of the transfer sequencer: counter states, strobe group and
  jumper group carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tsh_pkg;

  // Sequence counter states, Gray coded along 0-1-2-3-0
  typedef enum logic [1:0] {
    TSH_S0 = 2'h0,
    TSH_S1 = 2'h1,
    TSH_S2 = 2'h3,
    TSH_S3 = 2'h2
  } tsh_state_t;

  // Host transfer strobes, each active high
  typedef struct packed {
    logic direct_write_strobe;
    logic program_write_strobe;
    logic read_next_word;
    logic program_control_strobe;
    logic direct_control_strobe;
  } tsh_strobe_t;

  // Configuration jumpers, each high when installed
  typedef struct packed {
    logic start_edge_select;
    logic end_edge_select;
    logic pulse_mode_select;
    logic command_invert_select;
  } tsh_jumper_t;

endpackage

/* File: tb/tsh_periph_model.sv */
/* Behavioural parallel peripheral: one flag pulse per command.
   Assumes the bench sets answer delay and abort request. */
`timescale 1ns/10ps
module tsh_periph_model (
  // Clock
  input wire logic clk_sys,
  // Command and its polarity jumper
  input wire logic device_command,
  input wire logic invert,
  // Bench controls
  input wire logic [2:0] dly,
  input wire logic end_req,
  // Answers to the sequencer
  output logic device_flag,
  output logic device_end
);
  wire act = device_command ^ invert; // Command seen active
  logic act_q = 1'b0;
  logic inv_q = 1'b0; // Polarity seen at the last edge
  logic pend = 1'b0; // A command waits for its answer
  int ph = 0;
  int cnt = 0;

  initial begin
    device_flag = 1'b0;
    device_end = 1'b0;
  end

  // Flag rises a delay after each command, falls later; end only as an answer
  always @(posedge clk_sys) begin
    // A polarity jumper change flips act for one cycle; it is no command
    if (act && !act_q && invert == inv_q)
      pend = 1'b1;
    act_q = act;
    inv_q = invert;
    if (!end_req)
      device_end <= 1'b0;
    if (cnt != 0)
      cnt = cnt - 1;
    else if (ph == 0 && pend) begin
      pend = 1'b0;
      ph = 1;
      cnt = dly;
    end else if (ph == 1) begin
      device_flag <= 1'b1;
      device_end <= end_req;
      ph = 2;
      cnt = dly + 4;
    end else if (ph == 2) begin
      device_flag <= 1'b0;
      ph = 0;
      cnt = 3;
    end
  end
endmodule

/* File: tb/tsh_sequencer_checker.sv */
/* Port checker of the transfer sequencer.
   Assumes binding into tsh_sequencer and one clock clk_sys. */
`timescale 1ns/10ps
module tsh_sequencer_checker
  import tsh_pkg::*;
#(
  parameter int SETTLE_CYC = 2,
  parameter int PULSE_CYC = 80
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic master_reset_n,
  // Host side
  input wire tsh_strobe_t strobes,
  input wire logic [15:0] control_word,
  input wire tsh_jumper_t jumpers,
  // Peripheral side
  input wire logic device_flag,
  input wire logic device_end,
  input wire logic device_command,
  // Sequencer outputs
  input wire logic [3:0] count_onehot,
  input wire logic operation_done,
  input wire logic read_transfer,
  input wire logic write_transfer,
  input wire logic start_qualifier
);
  // Command with its polarity taken off
  wire cmd_act = device_command ^ jumpers.command_invert_select;
  logic s13_r; // Last cycle was S1 or S3
  logic [7:0] s1_cnt_r; // Cycles spent in S1
  logic [7:0] on_cnt_r; // Cycles of active command

  // Helper counters for the timed rules
  always_ff @(posedge clk_sys) begin
    s13_r <= count_onehot[1] | count_onehot[3];
    s1_cnt_r <= count_onehot[1] ? s1_cnt_r + 8'h01 : 8'h00;
    on_cnt_r <= cmd_act ? on_cnt_r + 8'h01 : 8'h00;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset || !master_reset_n);

  // Qualifier comes up within two edges of a taken strobe
  sequence qual_set_s;
    ##[1:2] start_qualifier;
  endsequence

  one_hot_a: assert property ($onehot(count_onehot))
    else $error("state outputs not one-hot");
  start_step_a: assert property (start_qualifier && count_onehot[0] && !device_end |=> count_onehot[1] && !start_qualifier)
    else $error("start qualifier did not step to S1");
  write_start_a: assert property ($fell(strobes.direct_write_strobe) && count_onehot[0] && !device_end |-> qual_set_s)
    else $error("write strobe trailing edge not taken");
  write_flag_a: assert property ($fell(strobes.program_write_strobe) |-> ##[1:2] write_transfer)
    else $error("write flag not set");
  read_flag_a: assert property ($fell(strobes.read_next_word) |-> ##[1:2] read_transfer && !write_transfer)
    else $error("read flag not set alone");
  ctl_gate_a: assert property ($fell(strobes.program_control_strobe) && !control_word[5] |=> !start_qualifier [*2])
    else $error("control strobe started without start bit");
  done_idle_a: assert property (operation_done |-> count_onehot[0])
    else $error("done outside S0");
  done_clear_a: assert property (operation_done && !(|strobes) |=> !read_transfer && !write_transfer)
    else $error("done left a transfer flag set");
  cmd_state_a: assert property (cmd_act && !jumpers.pulse_mode_select && $stable(jumpers) |-> s13_r)
    else $error("command outside S1 or S3");
  write_settle_a: assert property ($rose(cmd_act) && write_transfer && count_onehot[1] |-> s1_cnt_r >= 8'(SETTLE_CYC + 1))
    else $error("write command came too early");
  // Jumpers must have held for two edges, as a polarity change fakes a short command
  pulse_width_a: assert property ($fell(cmd_act) && jumpers.pulse_mode_select && $stable(jumpers)
    && jumpers == $past(jumpers, 2) |-> on_cnt_r == 8'(PULSE_CYC))
    else $error("command pulse width wrong");
  end_abort_a: assert property (device_end [*5] |-> count_onehot[0] && !cmd_act)
    else $error("device end did not force S0");
  word_pass_a: assert property (count_onehot[3] && !control_word[13] |=> count_onehot[0])
    else $error("word mode waited in S3");
endmodule

bind tsh_sequencer tsh_sequencer_checker #(.SETTLE_CYC(SETTLE_CYC), .PULSE_CYC(PULSE_CYC)) tsh_sequencer_checker_i (
  .clk_sys(clk_sys), .reset(reset), .master_reset_n(master_reset_n), .strobes(strobes),
  .control_word(control_word), .jumpers(jumpers), .device_flag(device_flag), .device_end(device_end),
  .device_command(device_command), .count_onehot(count_onehot), .operation_done(operation_done),
  .read_transfer(read_transfer), .write_transfer(write_transfer), .start_qualifier(start_qualifier));

/* File: tb/tsh_sequencer_test.sv */
/* Self-checking bench of the transfer sequencer.
   Assumes the sequencer, its bound checker and the peripheral model. */
`timescale 1ns/10ps
module tsh_sequencer_test;
  import tsh_pkg::*;
  localparam int SET_C = 2;
  localparam int PUL_C = 4;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic master_reset_n = 1'b1;
  tsh_strobe_t strobes = '0;
  logic [15:0] control_word = '0;
  tsh_jumper_t jumpers = '0;
  logic [2:0] dly = '0;
  logic end_req = 1'b0;
  wire logic device_flag, device_end, device_command, operation_done;
  wire logic read_transfer, write_transfer, start_qualifier;
  wire logic [3:0] count_onehot;
  int fails = 0;
  int check_count = 0;
  int ncmd = 0; // Commands seen in this operation
  int cyc = 0;
  logic act_q = 1'b0;

  tsh_sequencer #(.SETTLE_CYC(SET_C), .PULSE_CYC(PUL_C)) tsh_sequencer_i (
    .clk_sys(clk_sys), .reset(reset), .master_reset_n(master_reset_n), .strobes(strobes),
    .control_word(control_word), .jumpers(jumpers), .device_flag(device_flag), .device_end(device_end),
    .device_command(device_command), .count_onehot(count_onehot), .operation_done(operation_done),
    .read_transfer(read_transfer), .write_transfer(write_transfer), .start_qualifier(start_qualifier));
  tsh_periph_model tsh_periph_model_i (.clk_sys(clk_sys), .device_command(device_command),
    .invert(jumpers.command_invert_select), .dly(dly), .end_req(end_req),
    .device_flag(device_flag), .device_end(device_end));

  // 10 MHz clock
  initial forever #50 clk_sys = ~clk_sys;

  // Count command starts; cut a hang short
  always @(posedge clk_sys) begin
    act_q <= device_command ^ jumpers.command_invert_select;
    if ((device_command ^ jumpers.command_invert_select) && !act_q)
      ncmd++;
    cyc++;
    if (cyc == 40000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_state(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t state got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_cmds(input logic byte_mode);
    return byte_mode ? 8'h02 : 8'h01;
  endfunction

  function automatic logic exp_write(input int idx);
    return idx < 2;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One-cycle strobe, index 0 is the first struct member
  task automatic pulse_strobe(input int idx);
    @(posedge clk_sys);
    strobes <= tsh_strobe_t'(5'h10 >> idx);
    @(posedge clk_sys);
    strobes <= '0;
    repeat (3) @(negedge clk_sys);
  endtask

  // Whole operation with flag checks and command count
  task automatic run_op(input int idx, input tsh_jumper_t jp, input logic [15:0] cw);
    int n;
    @(posedge clk_sys);
    jumpers <= jp;
    control_word <= cw;
    dly <= 3'($urandom());
    repeat (3) @(negedge clk_sys);
    ncmd = 0;
    pulse_strobe(idx);
    chk_val({7'h00, write_transfer}, {7'h00, exp_write(idx)});
    chk_val({7'h00, read_transfer}, {7'h00, !exp_write(idx)});
    n = 0;
    while (operation_done !== 1'b1 && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    chk_val({7'h00, operation_done}, 8'h01);
    chk_val(8'(ncmd), exp_cmds(cw[13]));
    chk_state(count_onehot, 4'h1);
    @(negedge clk_sys);
    chk_val({6'h00, read_transfer, write_transfer}, 8'h00);
    // Let a late flag edge pass under this op's jumpers, so nothing stale is latched
    n = 0;
    while (device_flag !== 1'b0 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (4) @(negedge clk_sys);
    $display("test op %0d done", idx);
  endtask

  // Master reset pulse, then let the peripheral settle
  task automatic master_clear();
    @(posedge clk_sys);
    master_reset_n <= 1'b0;
    @(posedge clk_sys);
    master_reset_n <= 1'b1;
    @(negedge clk_sys);
    chk_state(count_onehot, 4'h1);
    chk_val({5'h00, start_qualifier, read_transfer, write_transfer}, 8'h00);
    repeat (30) @(negedge clk_sys);
  endtask

  initial begin
    tsh_jumper_t jp;
    logic [15:0] cw;
    void'($urandom(67));
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    // Every strobe kind, plain jumpers, word then byte mode
    for (int k = 0; k < 10; k++)
      run_op(k % 5, 4'h0, (k < 5) ? 16'h0020 : 16'h2020);
    // Random jumpers and words; pulse mode stays in word mode
    for (int k = 0; k < 30; k++) begin
      jp = tsh_jumper_t'(4'($urandom()));
      cw = 16'($urandom()) | 16'h0020;
      if (jp.pulse_mode_select)
        cw[13] = 1'b0;
      run_op(k % 5, jp, cw);
    end
    // Control strobes without the start bit only mark a read
    for (int k = 3; k < 5; k++) begin
      @(posedge clk_sys);
      jumpers <= 4'h0;
      control_word <= 16'h0000;
      pulse_strobe(k);
      repeat (10) @(negedge clk_sys);
      chk_state(count_onehot, 4'h1);
      chk_val({7'h00, read_transfer}, 8'h01);
      master_clear();
      $display("test no start %0d done", k);
    end
    // Peripheral abort, then a start held off while it lasts
    end_req <= 1'b1;
    run_op(2, 4'h0, 16'h0020);
    pulse_strobe(0);
    repeat (3) @(negedge clk_sys);
    chk_state(count_onehot, 4'h1);
    end_req <= 1'b0;
    master_clear();
    $display("test abort done");
    // Master reset in mid-transfer
    @(posedge clk_sys);
    control_word <= 16'h2020;
    dly <= 3'h7;
    pulse_strobe(1);
    master_clear();
    $display("test mid reset done");
    print_verdict();
  end
endmodule
